// ===== common/pin_mux_params.svh
// named constants for the two-pin output source selector
// assumes a byte-addressed wishbone bus with 32-bit data
`ifndef PIN_MUX_PARAMS_SVH
`define PIN_MUX_PARAMS_SVH

// ****************************************************************
// register map: word index, byte address is four times the index
// ****************************************************************
`define PIN_REG_IDX_W 6
`define PIN3_CTL_IDX 6'h13
`define PIN4_CTL_IDX 6'h14
`define PIN_STATUS_IDX 6'h18
`define PIN_CTL_RESET 8'h00
`define WB_DATA_W 32
`define WB_ADR_W 8
`define WB_ADR_IDX_LO 2
`define WB_ADR_IDX_HI 7

// ****************************************************************
// control register fields
// ****************************************************************
`define CTL_EN_BIT 0
`define CTL_VAL_BIT 1
`define CTL_W 8

// ****************************************************************
// source group codes
// ****************************************************************
`define SRC_RX0 3'h0
`define SRC_RX1 3'h1
`define SRC_RX2 3'h2
`define SRC_RX3 3'h3
`define SRC_DEV 3'h4
`define SRC_RSVD 3'h5
`define SRC_TX0 3'h6
`define SRC_TX1 3'h7

// ****************************************************************
// select codes
// ****************************************************************
`define SEL_0 3'h0
`define SEL_1 3'h1
`define SEL_2 3'h2
`define SEL_3 3'h3
`define SEL_4 3'h4
`define SEL_5 3'h5
`define SEL_6 3'h6
`define SEL_7 3'h7

// ****************************************************************
// status register bit positions
// ****************************************************************
`define STS_PIN3_LEVEL 0
`define STS_PIN3_DRIVE 1
`define STS_PIN3_IN 2
`define STS_PIN4_LEVEL 3
`define STS_PIN4_DRIVE 4
`define STS_PIN4_IN 5
`define STS_W 6

`define RX_PORTS 4
`define TX_PORTS 2
`define PINS 2

`endif

// ===== common/pin_mux_pkg.sv
// types shared by the pin source selector and its top level
// assumes pin_mux_params.svh is on the include path
`default_nettype none
`include "pin_mux_params.svh"

package pin_mux_pkg;

   // one receive port's status and forwarded remote pin values
   typedef struct packed {
      logic [3:0] fwd_pin;
      logic lock;
      logic pass;
      logic frame_valid;
      logic line_valid;
   } rx_status_s;

   // one transmit port's status; rx_select is the set of receive ports it merges
   typedef struct packed {
      logic [3:0] rx_select;
      logic frame_valid;
      logic line_valid;
      logic synced;
      logic irq;
   } tx_status_s;

   // register layout: sel 7:5, src 4:2, soft value 1, drive enable 0
   typedef struct packed {
      logic [2:0] signal_select;
      logic [2:0] source_group;
      logic soft_value;
      logic drive_enable;
   } pin_ctl_s;

endpackage

`default_nettype wire

// ===== hdl/pin_source_select.sv
// combinational source selector for one output pin
// assumes all status inputs are synchronous to the core clock
`timescale 1ns/1ns
`default_nettype none
`include "pin_mux_params.svh"

module pin_source_select #(
   parameter bit AND_PASS_AT_SEL2 = 1'b0
) (
   input wire pin_mux_pkg::pin_ctl_s i_ctl,
   input wire pin_mux_pkg::rx_status_s [3:0] i_rx,
   input wire logic [3:0] i_rx_enable,
   input wire pin_mux_pkg::tx_status_s [1:0] i_tx,
   input wire logic i_camera_sync_pulse,
   output logic o_level
);
   import pin_mux_pkg::*;

   logic [3:0] lock_v;
   logic [3:0] pass_v;
   logic any_lock;
   logic all_lock;
   logic all_pass;
   logic [1:0] tx_pass_and;
   logic [1:0] tx_pass_or;

   genvar g;
   generate
      for (g = 0; g < `RX_PORTS; g = g + 1) begin : g_rx
         assign lock_v[g] = i_rx[g].lock;
         assign pass_v[g] = i_rx[g].pass;
      end
      for (g = 0; g < `TX_PORTS; g = g + 1) begin : g_tx
         // empty selection reads as no pass
         assign tx_pass_and[g] = (|i_tx[g].rx_select) & (&(pass_v | ~i_tx[g].rx_select));
         assign tx_pass_or[g] = |(pass_v & i_tx[g].rx_select);
      end
   endgenerate

   // with no port enabled the AND terms read low, not vacuously high
   assign any_lock = |(lock_v & i_rx_enable);
   assign all_lock = (|i_rx_enable) & (&(lock_v | ~i_rx_enable));
   assign all_pass = (|i_rx_enable) & (&(pass_v | ~i_rx_enable));

   always_comb begin
      rx_status_s rx;
      tx_status_s tx;
      rx = i_rx[i_ctl.source_group[1:0]];
      tx = i_tx[i_ctl.source_group[0]];
      o_level = 1'b0;
      case (i_ctl.source_group)
         `SRC_RX0, `SRC_RX1, `SRC_RX2, `SRC_RX3: begin
            case (i_ctl.signal_select)
               `SEL_0, `SEL_1, `SEL_2, `SEL_3: o_level = rx.fwd_pin[i_ctl.signal_select[1:0]];
               `SEL_4: o_level = rx.lock;
               `SEL_5: o_level = rx.pass;
               `SEL_6: o_level = rx.frame_valid;
               default: o_level = rx.line_valid;
            endcase
         end
         `SRC_DEV: begin
            case (i_ctl.signal_select)
               `SEL_0: o_level = i_ctl.soft_value;
               `SEL_1: o_level = any_lock;
               `SEL_2: o_level = AND_PASS_AT_SEL2 ? all_pass : all_lock;
               `SEL_3: o_level = all_pass;
               `SEL_4: o_level = i_camera_sync_pulse;
               default: o_level = 1'b0;
            endcase
         end
         `SRC_TX0, `SRC_TX1: begin
            case (i_ctl.signal_select)
               `SEL_0: o_level = tx_pass_and[i_ctl.source_group[0]];
               `SEL_1: o_level = tx_pass_or[i_ctl.source_group[0]];
               `SEL_2: o_level = tx.frame_valid;
               `SEL_3: o_level = tx.line_valid;
               `SEL_4: o_level = tx.synced;
               `SEL_5: o_level = tx.irq;
               default: o_level = 1'b0;
            endcase
         end
         default: o_level = 1'b0;
      endcase
   end

endmodule // pin_source_select

`default_nettype wire

// ===== hdl/io_pin_output_source_mux.sv
// output source selection for two general-purpose pins, with wishbone registers
// assumes a classic wishbone master on i_clk and status inputs synchronous to it
//
// Chosen here: register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
`include "pin_mux_params.svh"

module io_pin_output_source_mux (
   input wire logic i_clk,
   input wire logic i_rst_n,
   // wishbone classic slave
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   // status from receive ports, transmit ports and sync generator
   input wire pin_mux_pkg::rx_status_s [3:0] i_rx_status,
   input wire logic [3:0] i_rx_enable,
   input wire pin_mux_pkg::tx_status_s [1:0] i_tx_status,
   input wire logic i_camera_sync_pulse,
   // pin 3
   input wire logic i_pin3_in,
   output logic o_pin3_out,
   output logic o_pin3_oe_n,
   // pin 4
   input wire logic i_pin4_in,
   output logic o_pin4_out,
   output logic o_pin4_oe_n
);
   import pin_mux_pkg::*;

   // ****************************************************************
   // bus decode
   // ****************************************************************
   logic [`PIN_REG_IDX_W-1:0] reg_idx;
   logic adr_aligned;
   logic req;
   logic hit_pin3;
   logic hit_pin4;
   logic hit_status;
   logic wr_commit;

   assign reg_idx = i_wb_adr[`WB_ADR_IDX_HI:`WB_ADR_IDX_LO];
   assign adr_aligned = (i_wb_adr[`WB_ADR_IDX_LO-1:0] == 2'h0);
   assign req = i_wb_cyc & i_wb_stb;
   assign hit_pin3 = adr_aligned & (reg_idx == `PIN3_CTL_IDX);
   assign hit_pin4 = adr_aligned & (reg_idx == `PIN4_CTL_IDX);
   assign hit_status = adr_aligned & (reg_idx == `PIN_STATUS_IDX);

   // the write lands on the same edge at which the master sees ack
   assign wr_commit = req & i_wb_we & o_wb_ack & i_wb_sel[0];

   // ****************************************************************
   // control registers
   // ****************************************************************
   pin_ctl_s [1:0] ctl_ff;
   pin_ctl_s [1:0] nxt_ctl;

   always_comb begin
      nxt_ctl = ctl_ff;
      if (wr_commit && hit_pin3) begin
         nxt_ctl[0] = pin_ctl_s'(i_wb_dat[`CTL_W-1:0]);
      end
      if (wr_commit && hit_pin4) begin
         nxt_ctl[1] = pin_ctl_s'(i_wb_dat[`CTL_W-1:0]);
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctl_ff[0] <= pin_ctl_s'(`PIN_CTL_RESET);
         ctl_ff[1] <= pin_ctl_s'(`PIN_CTL_RESET);
      end else begin
         ctl_ff <= nxt_ctl;
      end
   end

   // ****************************************************************
   // per-pin source selection
   // ****************************************************************
   logic [1:0] sel_level;
   logic [1:0] pin_in;

   assign pin_in = {i_pin4_in, i_pin3_in};

   genvar p;
   generate
      for (p = 0; p < `PINS; p = p + 1) begin : g_pin
         // the first pin keeps the pass-based AND at select 010
         pin_source_select #(
            .AND_PASS_AT_SEL2(p == 0)
         ) u_select (
            .i_ctl(ctl_ff[p]),
            .i_rx(i_rx_status),
            .i_rx_enable(i_rx_enable),
            .i_tx(i_tx_status),
            .i_camera_sync_pulse(i_camera_sync_pulse),
            .o_level(sel_level[p])
         );
      end
   endgenerate

   // ****************************************************************
   // pin output stage
   // ****************************************************************
   // registered so the pads see no decode glitches; costs one cycle of latency
   logic [1:0] pin_out_ff;
   logic [1:0] pin_oe_n_ff;
   logic [1:0] nxt_pin_out;
   logic [1:0] nxt_pin_oe_n;

   always_comb begin
      for (int i = 0; i < `PINS; i = i + 1) begin
         nxt_pin_oe_n[i] = ~ctl_ff[i].drive_enable;
         // low when not driving, so the level never leaks while released
         nxt_pin_out[i] = ctl_ff[i].drive_enable & sel_level[i];
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pin_out_ff <= 2'h0;
         pin_oe_n_ff <= 2'h3;
      end else begin
         pin_out_ff <= nxt_pin_out;
         pin_oe_n_ff <= nxt_pin_oe_n;
      end
   end

   assign o_pin3_out = pin_out_ff[0];
   assign o_pin3_oe_n = pin_oe_n_ff[0];
   assign o_pin4_out = pin_out_ff[1];
   assign o_pin4_oe_n = pin_oe_n_ff[1];

   // ****************************************************************
   // status view
   // ****************************************************************
   logic [`STS_W-1:0] status_word;

   always_comb begin
      status_word = '0;
      status_word[`STS_PIN3_LEVEL] = pin_out_ff[0];
      status_word[`STS_PIN3_DRIVE] = ~pin_oe_n_ff[0];
      status_word[`STS_PIN3_IN] = pin_in[0];
      status_word[`STS_PIN4_LEVEL] = pin_out_ff[1];
      status_word[`STS_PIN4_DRIVE] = ~pin_oe_n_ff[1];
      status_word[`STS_PIN4_IN] = pin_in[1];
   end

   // ****************************************************************
   // bus answer
   // ****************************************************************
   // every access is acked, unmapped ones read zero and drop writes
   logic ack_ff;
   logic nxt_ack;
   logic [31:0] rdat_ff;
   logic [31:0] nxt_rdat;

   always_comb begin
      nxt_ack = req & ~ack_ff;
      nxt_rdat = '0;
      if (req && !ack_ff) begin
         if (hit_pin3) begin
            nxt_rdat = {24'h0, ctl_ff[0]};
         end else if (hit_pin4) begin
            nxt_rdat = {24'h0, ctl_ff[1]};
         end else if (hit_status) begin
            nxt_rdat = {26'h0, status_word};
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ack_ff <= 1'b0;
         rdat_ff <= 32'h0;
      end else begin
         ack_ff <= nxt_ack;
         rdat_ff <= nxt_rdat;
      end
   end

   assign o_wb_ack = ack_ff;
   assign o_wb_dat = rdat_ff;

endmodule // io_pin_output_source_mux

`default_nettype wire

// ===== verif/pin_board_model.sv
// board side of the two pins: pull-down resistors on both pads
// assumes pads are driven only while the active-low enable is low
`timescale 1ns/1ns
`default_nettype none
module pin_board_model (
   input wire logic i_pin3_out,
   input wire logic i_pin3_oe_n,
   input wire logic i_pin4_out,
   input wire logic i_pin4_oe_n,
   output logic o_pin3_pad,
   output logic o_pin4_pad
);
   // ****************
   // pad levels
   // ****************
   // released pad falls to the pull-down, never keeps the last driven level
   assign o_pin3_pad = i_pin3_oe_n ? 1'b0 : i_pin3_out;
   assign o_pin4_pad = i_pin4_oe_n ? 1'b0 : i_pin4_out;
endmodule // pin_board_model
`default_nettype wire

// ===== verif/io_pin_output_source_mux_properties.sv
// port checker for the two-pin source selector
// assumes it is bound onto io_pin_output_source_mux
`timescale 1ns/1ns
`default_nettype none
module io_pin_output_source_mux_properties (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   input wire logic [31:0] o_wb_dat,
   input wire logic o_wb_ack,
   input wire logic o_pin3_out,
   input wire logic o_pin3_oe_n,
   input wire logic o_pin4_out,
   input wire logic o_pin4_oe_n
);
   // ****************
   // properties
   // ****************
   logic take;
   logic wr3;
   assign take = i_wb_cyc && i_wb_stb && !o_wb_ack;
   assign wr3 = take && i_wb_we && i_wb_sel[0] && i_wb_adr == 8'h4c;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   property p_ack_next; take |=> o_wb_ack; endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack late");
   property p_ack_pulse; o_wb_ack |=> !o_wb_ack; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
   property p_idle_zero; !o_wb_ack |-> o_wb_dat == 32'h0; endproperty
   a_idle_zero: assert property (p_idle_zero) else $error("read data idle");
   property p_off3; o_pin3_oe_n |-> !o_pin3_out; endproperty
   a_off3: assert property (p_off3) else $error("pin3 off but high");
   property p_off4; o_pin4_oe_n |-> !o_pin4_out; endproperty
   a_off4: assert property (p_off4) else $error("pin4 off but high");
   property p_rst; $rose(i_rst_n) |-> o_pin3_oe_n && o_pin4_oe_n; endproperty
   a_rst: assert property (p_rst) else $error("pin driven after reset");
   property p_en3; wr3 |-> ##3 o_pin3_oe_n == !$past(i_wb_dat[0], 3); endproperty
   a_en3: assert property (p_en3) else $error("pin3 enable wrong");
   property p_soft3;
      wr3 && i_wb_dat[7:2] == 6'h04 && i_wb_dat[0] |-> ##3 o_pin3_out == $past(i_wb_dat[1], 3);
   endproperty
   a_soft3: assert property (p_soft3) else $error("pin3 soft value");
endmodule // io_pin_output_source_mux_properties
bind io_pin_output_source_mux io_pin_output_source_mux_properties u_props (.i_clk(i_clk), .i_rst_n(i_rst_n),
   .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel),
   .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_pin3_out(o_pin3_out),
   .o_pin3_oe_n(o_pin3_oe_n), .o_pin4_out(o_pin4_out), .o_pin4_oe_n(o_pin4_oe_n));
`default_nettype wire

// ===== verif/io_pin_output_source_mux_tb.sv
// self-checking bench for the two-pin source selector
// assumes design, checker and board model compiled first
`timescale 1ns/1ns
`default_nettype none
module io_pin_output_source_mux_tb;
   import pin_mux_pkg::*;
   // ****************
   // stimulus and dut
   // ****************
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, sync = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0, rx_en = 4'h0;
   logic [31:0] wdat = 32'h0, rdat;
   rx_status_s [3:0] rx = 32'h0;
   tx_status_s [1:0] tx = 16'h0;
   logic ack, p3_out, p3_oe_n, p4_out, p4_oe_n, p3_pad, p4_pad;
   int errors = 0;
   int check_count = 0;
   always #25 i_clk = ~i_clk;
   io_pin_output_source_mux u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
      .i_rx_status(rx), .i_rx_enable(rx_en), .i_tx_status(tx), .i_camera_sync_pulse(sync),
      .i_pin3_in(p3_pad), .o_pin3_out(p3_out), .o_pin3_oe_n(p3_oe_n),
      .i_pin4_in(p4_pad), .o_pin4_out(p4_out), .o_pin4_oe_n(p4_oe_n));
   pin_board_model u_board (.i_pin3_out(p3_out), .i_pin3_oe_n(p3_oe_n), .i_pin4_out(p4_out),
      .i_pin4_oe_n(p4_oe_n), .o_pin3_pad(p3_pad), .o_pin4_pad(p4_pad));
   task automatic stop_test;
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one classic cycle; waits for ack, only the watchdog ends a hang
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
      output logic [31:0] q);
      @(posedge i_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= s;
      do begin
         @(posedge i_clk);
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   function automatic logic all_on(input logic [3:0] v, input logic [3:0] m);
      return m != 4'h0 && (v | ~m) == 4'hf;
   endfunction
   function automatic logic level(input int p, input logic [7:0] c);
      logic [3:0] lk;
      logic [3:0] ps;
      tx_status_s t;
      for (int i = 0; i < 4; i++) begin
         lk[i] = rx[i].lock;
         ps[i] = rx[i].pass;
      end
      t = tx[c[2]];
      if (!c[4]) return c[7] ? rx[c[3:2]][7 - c[7:5]] : rx[c[3:2]][4 + c[6:5]];
      if (c[4:2] == 3'h4) case (c[7:5])
         3'h0: return c[1];
         3'h1: return |(lk & rx_en);
         3'h2: return all_on(p ? lk : ps, rx_en);
         3'h3: return all_on(ps, rx_en);
         3'h4: return sync;
         default: return 1'b0;
      endcase
      if (c[4:3] == 2'h3) case (c[7:5])
         3'h0: return all_on(ps, t.rx_select);
         3'h1: return |(ps & t.rx_select);
         3'h2, 3'h3, 3'h4, 3'h5: return t[5 - c[7:5]];
         default: return 1'b0;
      endcase
      return 1'b0;
   endfunction
   // ****************
   // scenarios
   // ****************
   task automatic t_reset;
      logic [31:0] q;
      @(posedge i_clk);
      i_rst_n <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_rst_n <= 1'b1;
      chk({p3_oe_n, p4_oe_n, p3_out, p4_out}, 4'hc);
      wb(1'b0, 8'h4c, 32'h0, 4'hf, q);
      chk(q, 32'h0);
      wb(1'b0, 8'h50, 32'h0, 4'hf, q);
      chk(q, 32'h0);
   endtask
   // refused writes must leave 0x5a; pin3 stays released
   task automatic t_bus;
      logic [31:0] q;
      wb(1'b1, 8'h4c, 32'hffffff5a, 4'hf, q);
      wb(1'b1, 8'h4c, 32'h0, 4'he, q);
      wb(1'b1, 8'h4d, 32'h0, 4'hf, q);
      wb(1'b1, 8'h60, 32'hff, 4'hf, q);
      wb(1'b0, 8'h4c, 32'h0, 4'hf, q);
      chk(q, 32'h5a);
      wb(1'b0, 8'h44, 32'h0, 4'hf, q);
      chk(q, 32'h0);
      wb(1'b1, 8'h50, 32'h12, 4'h1, q);
      repeat (2) @(posedge i_clk);
      chk({p4_out, p4_oe_n}, 2'h1);
      wb(1'b1, 8'h50, 32'h13, 4'h1, q);
      repeat (2) @(posedge i_clk);
      wb(1'b0, 8'h60, 32'h0, 4'hf, q);
      chk(q, 32'h38);
   endtask
   // every source and select code on both pins, three status patterns
   task automatic t_mux;
      logic [31:0] q;
      logic [7:0] c;
      for (int p = 0; p < 2; p++) begin
         for (int k = 0; k < 3; k++) begin
            @(posedge i_clk);
            rx <= k == 0 ? 32'h5a3c96e1 : k == 1 ? 32'ha5c3691e : 32'hffffffff;
            // k 0: no enabled lock; k 1: all lock but not all pass; tx1 at k 0 mixes pass and fail
            rx_en <= k == 2 ? 4'h5 : 4'h3;
            tx <= k == 0 ? 16'h3c63 : k == 1 ? 16'h639c : 16'hfefe;
            sync <= k != 1;
            for (int n = 0; n < 64; n++) begin
               c = {n[5:0], k[0], 1'b1};
               wb(1'b1, 8'h4c + 8'(4 * p), {24'h0, c}, 4'h1, q);
               repeat (2) @(posedge i_clk);
               chk({p ? p4_out : p3_out, p ? p4_oe_n : p3_oe_n}, {level(p, c), 1'b0});
            end
         end
      end
   endtask
   initial begin
      t_reset;
      t_bus;
      t_mux;
      t_reset;
      stop_test;
   end
   initial begin
      #2000000;
      errors++;
      stop_test;
   end
endmodule // io_pin_output_source_mux_tb
`default_nettype wire
